//--- logic/ctrl_word_pkg.sv
// Purpose: shared constants for the converter control word block
// Assumes: 7-bit register addresses, 16-bit register data, 100 MHz clock
// Notes: the address ranges cover the converter data registers only
package ctrl_word_pkg;
  // bus geometry
  localparam int ADDR_W = 7;
  localparam int DATA_W = 16;
  localparam int ADC_CHANS = 16;
  localparam int ADC_IDX_W = 4;
  localparam int DAC_CHANS = 12;
  localparam int DAC_W = 12;

  // register addresses
  localparam logic [6:0] CTRL_WORD_ADDR = 7'h4C;
  localparam logic [6:0] ADC_DATA_FIRST = 7'h23;
  localparam logic [6:0] ADC_DATA_LAST = 7'h32;
  localparam logic [6:0] DAC_DATA_FIRST = 7'h33;
  localparam logic [6:0] DAC_DATA_LAST = 7'h3E;

  // control word field positions
  localparam int MODE_BIT = 13;
  localparam int TRIG_BIT = 12;
  localparam int LOAD_BIT = 11;
  localparam int REF_BIT = 10;
  localparam int ALARM_EN_BIT = 9;
  localparam int READY_BIT = 7;

  // control word reset value and per-field resets
  localparam logic [15:0] CTRL_WORD_RST = 16'h2000;
  localparam logic MODE_RST = CTRL_WORD_RST[MODE_BIT];
  localparam logic TRIG_RST = CTRL_WORD_RST[TRIG_BIT];
  localparam logic LOAD_RST = CTRL_WORD_RST[LOAD_BIT];
  localparam logic REF_RST = CTRL_WORD_RST[REF_BIT];
  localparam logic ALARM_EN_RST = CTRL_WORD_RST[ALARM_EN_BIT];
  localparam logic READY_RST = CTRL_WORD_RST[READY_BIT];

  // ready pulse timing in continuous mode
  localparam int CLK_PERIOD_NS = 10;
  localparam int READY_PULSE_NS = 1000;
  localparam int READY_PULSE_CYCLES = READY_PULSE_NS / CLK_PERIOD_NS;
  localparam int PULSE_CNT_W = $clog2(READY_PULSE_CYCLES + 1);

  // channel search result: top bit set means no channel found
  localparam logic [4:0] CHAN_NONE = 5'h10;
endpackage : ctrl_word_pkg

//--- logic/conv_sequencer.sv
// Purpose: steps the input multiplexer through the selected channels
// Assumes: conv_done_i is a one-cycle pulse from the converter core
// Notes: the channel mask is captured when a sequence starts from idle; continuous-mode repeats reuse it
`timescale 1ns/1ps
module conv_sequencer
(
  input wire logic clk_i,          // system clock
  input wire logic arst_n_i,       // async reset, active low
  input wire logic start_i,        // pending trigger
  input wire logic cont_mode_i,    // 1 = repeat sequences
  input wire logic [15:0] chan_mask_i, // selected inputs
  input wire logic conv_done_i,    // converter finished a channel
  output logic conv_start_o,       // start one channel conversion
  output logic [3:0] conv_chan_o,  // multiplexer channel
  output logic seq_begin_o,        // pulse: sequence started
  output logic seq_end_o,          // pulse: last channel finished
  output logic busy_o              // sequence in progress
);
  typedef enum {SEQ_IDLE, SEQ_WAIT} seq_state_e;

  seq_state_e state_r;
  logic [15:0] mask_r;

  // lowest selected channel at or above a start index
  function automatic logic [4:0] find_from(input logic [15:0] mask,
                                           input logic [4:0] from);
    logic [4:0] res;
    res = ctrl_word_pkg::CHAN_NONE;
    for (int k = 15; k >= 0; k--)
    begin
      if (mask[k] && (5'(k) >= from))
        res = 5'(k);
    end
    return res;
  endfunction : find_from

  // a sequence with an empty mask begins and ends in the same cycle
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    logic [4:0] pick;
    if (!arst_n_i)
    begin
      state_r <= SEQ_IDLE;
      mask_r <= 16'h0000;
      conv_start_o <= 1'b0;
      conv_chan_o <= 4'h0;
      seq_begin_o <= 1'b0;
      seq_end_o <= 1'b0;
    end
    else
    begin
      // scratch pick is only set off the reset branch
      pick = 5'h00;
      conv_start_o <= 1'b0;
      seq_begin_o <= 1'b0;
      seq_end_o <= 1'b0;
      case (state_r)
        SEQ_IDLE:
        begin
          if (start_i)
          begin
            seq_begin_o <= 1'b1;
            mask_r <= chan_mask_i;
            pick = find_from(chan_mask_i, 5'h00);
            if (pick[4])
              seq_end_o <= 1'b1;
            else
            begin
              conv_chan_o <= pick[3:0];
              conv_start_o <= 1'b1;
              state_r <= SEQ_WAIT;
            end
          end
        end
        SEQ_WAIT:
        begin
          if (conv_done_i)
          begin
            pick = find_from(mask_r, 5'(conv_chan_o) + 5'h01);
            if (!pick[4])
            begin
              conv_chan_o <= pick[3:0];
              conv_start_o <= 1'b1;
            end
            else
            begin
              seq_end_o <= 1'b1;
              pick = find_from(mask_r, 5'h00);
              if (cont_mode_i)
              begin
                // back to the first selected channel
                seq_begin_o <= 1'b1;
                conv_chan_o <= pick[3:0];
                conv_start_o <= 1'b1;
              end
              else
                state_r <= SEQ_IDLE;
            end
          end
        end
        default: state_r <= SEQ_IDLE;
      endcase
    end
  end

  assign busy_o = (state_r == SEQ_WAIT);
endmodule : conv_sequencer

//--- logic/adc_dac_control_word.sv
// Purpose: converter control and status word with sequencing and load
// Assumes: a serial decoder outside presents one-cycle register strobes
// Notes: output converter data registers live here to track writes
//
// Summary of operation
// (RULE_01) Bits 15, 14 and 8 ignore writes and read as zero.
// (RULE_02) Mode 0: convert selected inputs once in order, then idle.
// (RULE_03) Mode 1: after last channel, return to first and repeat.
// (RULE_04) Repeat until mode written 0; mode bit resets to 1.
// (RULE_05) Trigger bit 1 starts a sequence; clears itself once begun.
// (RULE_06) Load bit 1 moves synchronous channels' data into latches.
// (RULE_07) Only synchronous channels written since last load are reloaded.
// (RULE_08) Outputs follow latches at once; load bit clears after transfer.
// (RULE_09) Reference bit 0: internal buffer off, external reference used.
// (RULE_10) Reference bit 1: internal buffer on, internal reference used.
// (RULE_11) Bit 9 enables the active-low alarm pin; resets to 0.
// (RULE_12) Mode 0: ready flag reads 1 when a sequence has finished.
// (RULE_13) Mode 1: ready flag held at 0.
// (RULE_14) Mode 0: ready pin is the inverse of the ready flag.
// (RULE_15) Mode 1: one 1 us low pulse on ready pin per sequence end.
// (RULE_16) Flag clears on data read, new conversion, or written 0.
// (RULE_17) Status register reads leave the ready flag alone.
// (RULE_18) Writing 0 to trigger or load bits does nothing.
// (RULE_19) Host waits for flag or pin before reading one-shot results.
`timescale 1ns/1ps
module adc_dac_control_word
#(
  parameter int DAC_N = ctrl_word_pkg::DAC_CHANS,   // output converters
  parameter int DAC_BITS = ctrl_word_pkg::DAC_W     // converter width
)
(
  input wire logic CLK_SYS_I,                 // 100 MHz system clock
  input wire logic ARST_N_I,                  // async reset, active low
  input wire logic REG_WR_I,                  // register write strobe
  input wire logic REG_RD_I,                  // register read strobe
  input wire logic [6:0] REG_ADDR_I,          // register address
  input wire logic [15:0] REG_WDATA_I,        // write data
  output logic [15:0] REG_RDATA_O,            // read data, registered
  output logic REG_RVALID_O,                  // read data valid pulse
  input wire logic [15:0] CHAN_SELECT_I,      // selected analog inputs
  input wire logic ADC_CONV_DONE_I,           // channel conversion done
  output logic ADC_CONV_START_O,              // start channel conversion
  output logic [3:0] ADC_CHAN_O,              // multiplexer channel
  input wire logic [DAC_N-1:0] OUTPUT_SYNC_UPDATE_SELECT_I, // 1 = sync
  output logic [DAC_N*DAC_BITS-1:0] DAC_LATCH_O, // latched codes
  output logic REF_BUF_EN_O,                  // internal buffer powered
  output logic REF_INT_SEL_O,                 // 1 = internal reference
  input wire logic ALARM_ACTIVE_I,            // alarm condition present
  output logic ALARM_N_O,                     // alarm pin, active low
  output logic RESULTS_READY_PIN_N_O          // ready pin, active low
);
  localparam int PCW = ctrl_word_pkg::PULSE_CNT_W;
  localparam logic [PCW-1:0] PULSE_LOAD =
    PCW'(ctrl_word_pkg::READY_PULSE_CYCLES);

  // control word fields
  logic conversion_mode_select_r;
  logic soft_convert_trigger_r;
  logic soft_output_load_r;
  logic ref_internal_r;
  logic alarm_enable_r;
  logic results_ready_flag_r;
  logic [PCW-1:0] pulse_cnt_r;

  // output converter storage
  logic [DAC_N*DAC_BITS-1:0] dac_data_r;
  logic [DAC_N*DAC_BITS-1:0] dac_latch_r;
  logic [DAC_N-1:0] dac_dirty_r;

  // decode
  logic ctrl_wr;
  logic adc_rd;
  logic dac_wr;
  logic dac_rd;
  logic [6:0] dac_off;
  logic [3:0] dac_idx;
  logic [15:0] ctrl_word;
  logic [15:0] rdata_nxt;

  // sequencer hand-off
  logic seq_begin;
  logic seq_end;
  logic seq_busy;

  // address window test, shared by several decodes
  function automatic logic in_range(input logic [6:0] a,
                                    input logic [6:0] lo,
                                    input logic [6:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction : in_range

  // register strobe decode; status reads are simply not decoded here
  assign ctrl_wr = REG_WR_I && (REG_ADDR_I == ctrl_word_pkg::CTRL_WORD_ADDR);
  assign adc_rd = REG_RD_I && in_range(REG_ADDR_I,
    ctrl_word_pkg::ADC_DATA_FIRST, ctrl_word_pkg::ADC_DATA_LAST); // RULE_16
  assign dac_wr = REG_WR_I && in_range(REG_ADDR_I,
    ctrl_word_pkg::DAC_DATA_FIRST, ctrl_word_pkg::DAC_DATA_LAST);
  assign dac_rd = REG_RD_I && in_range(REG_ADDR_I,
    ctrl_word_pkg::DAC_DATA_FIRST, ctrl_word_pkg::DAC_DATA_LAST);
  assign dac_off = REG_ADDR_I - ctrl_word_pkg::DAC_DATA_FIRST;
  assign dac_idx = dac_off[3:0];

  // readback image; reserved and lower bits stay zero
  always_comb
  begin
    ctrl_word = 16'h0000; // RULE_01
    ctrl_word[ctrl_word_pkg::MODE_BIT] = conversion_mode_select_r;
    ctrl_word[ctrl_word_pkg::TRIG_BIT] = soft_convert_trigger_r;
    ctrl_word[ctrl_word_pkg::LOAD_BIT] = soft_output_load_r;
    ctrl_word[ctrl_word_pkg::REF_BIT] = ref_internal_r;
    ctrl_word[ctrl_word_pkg::ALARM_EN_BIT] = alarm_enable_r;
    ctrl_word[ctrl_word_pkg::READY_BIT] = results_ready_flag_r;
  end

  // read mux; unmapped addresses answer zero
  always_comb
  begin
    rdata_nxt = 16'h0000;
    if (REG_ADDR_I == ctrl_word_pkg::CTRL_WORD_ADDR)
      rdata_nxt = ctrl_word;
    else if (dac_rd && (int'(dac_idx) < DAC_N))
      rdata_nxt = 16'(dac_data_r[int'(dac_idx)*DAC_BITS +: DAC_BITS]);
  end

  // read data register
  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      REG_RDATA_O <= 16'h0000;
      REG_RVALID_O <= 1'b0;
    end
    else
    begin
      REG_RVALID_O <= REG_RD_I;
      if (REG_RD_I)
        REG_RDATA_O <= rdata_nxt;
    end
  end

  // mode: stops only at the end of the running sequence
  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
      conversion_mode_select_r <= ctrl_word_pkg::MODE_RST; // RULE_04
    else if (ctrl_wr)
      conversion_mode_select_r <= REG_WDATA_I[ctrl_word_pkg::MODE_BIT];
  end

  // trigger: a new write of 1 beats the self-clear in the same cycle
  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
      soft_convert_trigger_r <= ctrl_word_pkg::TRIG_RST;
    else if (ctrl_wr && REG_WDATA_I[ctrl_word_pkg::TRIG_BIT])
      soft_convert_trigger_r <= 1'b1; // RULE_05
    else if (seq_begin)
      soft_convert_trigger_r <= 1'b0; // RULE_05
    // a written 0 leaves the bit as it is
  end // RULE_18

  // load strobe: held one cycle, cleared after the transfer
  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
      soft_output_load_r <= ctrl_word_pkg::LOAD_RST;
    else if (ctrl_wr && REG_WDATA_I[ctrl_word_pkg::LOAD_BIT])
      soft_output_load_r <= 1'b1; // RULE_18
    else if (soft_output_load_r)
      soft_output_load_r <= 1'b0; // RULE_08
  end

  // reference select and alarm enable
  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      ref_internal_r <= ctrl_word_pkg::REF_RST;
      alarm_enable_r <= ctrl_word_pkg::ALARM_EN_RST; // RULE_11
    end
    else if (ctrl_wr)
    begin
      ref_internal_r <= REG_WDATA_I[ctrl_word_pkg::REF_BIT];
      alarm_enable_r <= REG_WDATA_I[ctrl_word_pkg::ALARM_EN_BIT];
    end
  end

  // reference pins follow the select bit; both flops for clean outputs
  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      REF_BUF_EN_O <= 1'b0;
      REF_INT_SEL_O <= 1'b0;
    end
    else
    begin
      REF_BUF_EN_O <= ref_internal_r;  // RULE_09 RULE_10
      REF_INT_SEL_O <= ref_internal_r; // RULE_09 RULE_10
    end
  end

  // alarm pin idles high while disabled
  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
      ALARM_N_O <= 1'b1;
    else
      ALARM_N_O <= ~(alarm_enable_r & ALARM_ACTIVE_I); // RULE_11
  end

  // channel sequencing
  conv_sequencer u_seq
  (
    .clk_i(CLK_SYS_I),
    .arst_n_i(ARST_N_I),
    .start_i(soft_convert_trigger_r),       // RULE_02
    .cont_mode_i(conversion_mode_select_r), // RULE_03
    .chan_mask_i(CHAN_SELECT_I),
    .conv_done_i(ADC_CONV_DONE_I),
    .conv_start_o(ADC_CONV_START_O),
    .conv_chan_o(ADC_CHAN_O),
    .seq_begin_o(seq_begin),
    .seq_end_o(seq_end),
    .busy_o(seq_busy)
  );

  // ready flag: in mode 0 a finishing sequence beats any clear in the same cycle
  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
      results_ready_flag_r <= ctrl_word_pkg::READY_RST;
    else if (conversion_mode_select_r)
      results_ready_flag_r <= 1'b0; // RULE_13
    else if (seq_end)
      results_ready_flag_r <= 1'b1; // RULE_12
    else if (seq_begin || adc_rd || seq_busy ||
             (ctrl_wr && !REG_WDATA_I[ctrl_word_pkg::READY_BIT]))
      results_ready_flag_r <= 1'b0; // RULE_16 RULE_17
  end

  // continuous-mode pulse width counter
  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
      pulse_cnt_r <= '0;
    else if (!conversion_mode_select_r)
      pulse_cnt_r <= '0;
    else if (seq_end)
      pulse_cnt_r <= PULSE_LOAD; // RULE_15
    else if (pulse_cnt_r != '0)
      pulse_cnt_r <= pulse_cnt_r - PCW'(1);
  end

  // ready pin, one cycle behind its source
  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
      RESULTS_READY_PIN_N_O <= 1'b1;
    else if (conversion_mode_select_r)
      RESULTS_READY_PIN_N_O <= (pulse_cnt_r == '0); // RULE_15
    else
      RESULTS_READY_PIN_N_O <= ~results_ready_flag_r; // RULE_14
  end

  // data registers take every write, whatever the update mode
  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
      dac_data_r <= '0;
    else
    begin
      for (int i = 0; i < DAC_N; i++)
      begin
        if (dac_wr && (int'(dac_idx) == i))
          dac_data_r[i*DAC_BITS +: DAC_BITS] <= REG_WDATA_I[DAC_BITS-1:0];
      end
    end
  end

  // written-since-load marks; a write beats the clear of the same cycle
  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
      dac_dirty_r <= '0;
    else
    begin
      for (int i = 0; i < DAC_N; i++)
      begin
        if (dac_wr && (int'(dac_idx) == i))
          dac_dirty_r[i] <= OUTPUT_SYNC_UPDATE_SELECT_I[i]; // RULE_07
        else if (soft_output_load_r && OUTPUT_SYNC_UPDATE_SELECT_I[i])
          dac_dirty_r[i] <= 1'b0; // RULE_07
      end
    end
  end

  // latches: async channels follow writes, sync ones wait for the load;
  // a write landing with the load goes out on the next load, not this one
  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
      dac_latch_r <= '0;
    else
    begin
      for (int i = 0; i < DAC_N; i++)
      begin
        if (!OUTPUT_SYNC_UPDATE_SELECT_I[i])
        begin
          if (dac_wr && (int'(dac_idx) == i))
            dac_latch_r[i*DAC_BITS +: DAC_BITS] <=
              REG_WDATA_I[DAC_BITS-1:0];
        end
        else if (soft_output_load_r && dac_dirty_r[i]) // RULE_06 RULE_07
          dac_latch_r[i*DAC_BITS +: DAC_BITS] <=
            dac_data_r[i*DAC_BITS +: DAC_BITS]; // RULE_06
      end
    end
  end

  // converter codes leave straight from the latches
  assign DAC_LATCH_O = dac_latch_r; // RULE_08
endmodule : adc_dac_control_word

//--- bench/ctrl_word_chk.sv
// Purpose: port checks for the converter control word block
// Assumes: conversion mode shadowed from control word writes
// Notes: bound to every instance of the block
`timescale 1ns/1ps
module ctrl_word_chk
#(
  parameter int DAC_N = 12, // output converters
  parameter int DAC_BITS = 12 // converter width
)
(
  input wire logic CLK_SYS_I, // clock
  input wire logic ARST_N_I, // reset
  input wire logic REG_WR_I, // write strobe
  input wire logic REG_RD_I, // read strobe
  input wire logic [6:0] REG_ADDR_I, // address
  input wire logic [15:0] REG_WDATA_I, // write data
  input wire logic [15:0] REG_RDATA_O, // read data
  input wire logic REG_RVALID_O, // read valid
  input wire logic [15:0] CHAN_SELECT_I, // input mask
  input wire logic ADC_CONV_START_O, // channel start
  input wire logic [3:0] ADC_CHAN_O, // channel
  input wire logic [DAC_N*DAC_BITS-1:0] DAC_LATCH_O, // latches
  input wire logic REF_BUF_EN_O, // buffer on
  input wire logic REF_INT_SEL_O, // internal ref
  input wire logic ALARM_ACTIVE_I, // alarm cause
  input wire logic ALARM_N_O, // alarm pin
  input wire logic RESULTS_READY_PIN_N_O // ready pin
);
  logic mode_r;
  logic [7:0] low_cnt_r;
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!ARST_N_I);
  // mode shadow: the pin pulse width only applies in auto mode
  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I)
    if (!ARST_N_I) mode_r <= 1'h1;
    else if (REG_WR_I && REG_ADDR_I == 7'h4C) mode_r <= REG_WDATA_I[13];
  // length of the current low phase of the ready pin, saturating
  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I)
    if (!ARST_N_I) low_cnt_r <= 8'h00;
    else if (RESULTS_READY_PIN_N_O) low_cnt_r <= 8'h00;
    else if (low_cnt_r != 8'hFF) low_cnt_r <= low_cnt_r + 8'h01;
  reserved_zero_a: assert property (REG_RD_I && REG_ADDR_I == 7'h4C
    |=> REG_RDATA_O[15:14] == 2'h0 && !REG_RDATA_O[8])
    else $error("reserved control bits read nonzero");
  rd_answer_a: assert property (REG_RD_I |=> REG_RVALID_O)
    else $error("read not answered next cycle");
  ref_pair_a: assert property (REF_BUF_EN_O == REF_INT_SEL_O)
    else $error("reference buffer and select disagree");
  ref_write_a: assert property (REG_WR_I && REG_ADDR_I == 7'h4C
    |-> ##2 REF_INT_SEL_O == $past(REG_WDATA_I[10], 2))
    else $error("reference select not following write");
  alarm_idle_a: assert property (!ALARM_ACTIVE_I |=> ALARM_N_O)
    else $error("alarm pin low without alarm");
  start_sel_a: assert property (ADC_CONV_START_O
    |-> CHAN_SELECT_I[ADC_CHAN_O])
    else $error("unselected channel converted");
  start_pulse_a: assert property (ADC_CONV_START_O |=> !ADC_CONV_START_O)
    else $error("start longer than one cycle");
  pulse_len_a: assert property ($rose(RESULTS_READY_PIN_N_O) && mode_r
    && $past(mode_r, 120) |-> low_cnt_r == 8'h64)
    else $error("auto mode ready pulse width wrong");
  auto_low_a: assert property (mode_r && $past(mode_r, 120)
    |-> low_cnt_r <= 8'h64)
    else $error("ready pin held low in auto mode");
  latch_cause_a: assert property ($changed(DAC_LATCH_O) |-> $past(REG_WR_I)
    || $past(REG_WR_I, 2) || $past(REG_WR_I, 3))
    else $error("latch changed without a write");
  start_c: cover property (ADC_CONV_START_O);
  pulse_c: cover property ($rose(RESULTS_READY_PIN_N_O) && mode_r);
  load_c: cover property (REG_WR_I && REG_ADDR_I == 7'h4C && REG_WDATA_I[11]);
endmodule : ctrl_word_chk
bind adc_dac_control_word ctrl_word_chk #(.DAC_N(DAC_N), .DAC_BITS(DAC_BITS))
  chk_u (.CLK_SYS_I(CLK_SYS_I), .ARST_N_I(ARST_N_I), .REG_WR_I(REG_WR_I),
  .REG_RD_I(REG_RD_I), .REG_ADDR_I(REG_ADDR_I), .REG_WDATA_I(REG_WDATA_I),
  .REG_RDATA_O(REG_RDATA_O), .REG_RVALID_O(REG_RVALID_O),
  .CHAN_SELECT_I(CHAN_SELECT_I), .ADC_CONV_START_O(ADC_CONV_START_O),
  .ADC_CHAN_O(ADC_CHAN_O), .DAC_LATCH_O(DAC_LATCH_O),
  .REF_BUF_EN_O(REF_BUF_EN_O), .REF_INT_SEL_O(REF_INT_SEL_O),
  .ALARM_ACTIVE_I(ALARM_ACTIVE_I), .ALARM_N_O(ALARM_N_O),
  .RESULTS_READY_PIN_N_O(RESULTS_READY_PIN_N_O));

//--- bench/conv_core_model.sv
// Purpose: converter core answering each channel start with a done pulse
// Assumes: no new start arrives before the previous done
// Notes: latency is set by the bench to run fast and slow
`timescale 1ns/1ps
module conv_core_model
(
  input wire logic clk_i, // system clock
  input wire logic start_i, // channel start from the block
  input wire logic [3:0] lat_i, // cycles until done, 1 or more
  output logic done_o // one-cycle done pulse
);
  int cnt = 0;
  initial done_o = 1'h0;
  // count down from each start, then pulse done for one cycle
  always @(posedge clk_i)
  begin
    done_o <= 1'h0;
    if (start_i) cnt <= int'(lat_i);
    else if (cnt == 1)
    begin
      done_o <= 1'h1;
      cnt <= 0;
    end
    else if (cnt > 1) cnt <= cnt - 1;
  end
endmodule : conv_core_model

//--- bench/tb_top.sv
// Purpose: self-checking bench for the converter control word block
// Assumes: converter core modelled by conv_core_model
// Notes: inputs change on the falling clock edge
`timescale 1ns/1ps
module tb_top;
  logic clk, arst_n, reg_wr, rd, rvalid, done, start, ref_en, ref_sel;
  logic alarm, alarm_n, pin_n;
  logic [6:0] addr;
  logic [15:0] wdata, rdata, mask, v;
  logic [3:0] chan, lat;
  logic [11:0] sync_sel, dval;
  logic [143:0] latch, exp_latch;
  logic [143:0] pend_latch = '0;
  int fails = 0;
  int samples_checked = 0;
  int cyc = 0;
  int chq[$];
  int expq[$];
  adc_dac_control_word dut_u (.CLK_SYS_I(clk), .ARST_N_I(arst_n),
    .REG_WR_I(reg_wr), .REG_RD_I(rd), .REG_ADDR_I(addr),
    .REG_WDATA_I(wdata), .REG_RDATA_O(rdata), .REG_RVALID_O(rvalid),
    .CHAN_SELECT_I(mask), .ADC_CONV_DONE_I(done),
    .ADC_CONV_START_O(start), .ADC_CHAN_O(chan),
    .OUTPUT_SYNC_UPDATE_SELECT_I(sync_sel), .DAC_LATCH_O(latch),
    .REF_BUF_EN_O(ref_en), .REF_INT_SEL_O(ref_sel),
    .ALARM_ACTIVE_I(alarm), .ALARM_N_O(alarm_n),
    .RESULTS_READY_PIN_N_O(pin_n));
  conv_core_model core_u (.clk_i(clk), .start_i(start), .lat_i(lat),
    .done_o(done));
  // 100 MHz clock
  initial
  begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  // record every channel the block starts
  always @(posedge clk)
    if (start === 1'h1) chq.push_back(int'(chan));
  task automatic summarize();
    $display("checked %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : summarize
  // hang guard well above the expected run length
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      fails++;
      summarize();
    end
  end
  task automatic chk(input string n, input logic [143:0] s, e);
    samples_checked++;
    if (s !== e)
    begin
      fails++;
      $display("MISMATCH %s exp %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic bus_wr(input logic [6:0] a, input logic [15:0] d);
    @(negedge clk);
    reg_wr = 1'h1;
    addr = a;
    wdata = d;
    @(negedge clk);
    reg_wr = 1'h0;
  endtask : bus_wr
  task automatic bus_rd(input logic [6:0] a, output logic [15:0] d);
    @(negedge clk);
    rd = 1'h1;
    addr = a;
    @(negedge clk);
    rd = 1'h0;
    chk("rvalid", rvalid, 1'h1);
    d = rdata;
  endtask : bus_rd
  // bounded wait for the ready pin to reach a level
  task automatic wait_pin(input logic lvl);
    int n;
    n = 0;
    while (pin_n !== lvl && n < 3000)
    begin
      @(negedge clk);
      n++;
    end
    chk("pin_n", pin_n, lvl);
  endtask : wait_pin
  // compare started channels with reps passes over the mask, in order
  task automatic check_seq(input int reps);
    int n;
    n = 0;
    expq.delete();
    for (int i = 0; i < 16; i++)
      if (mask[i]) expq.push_back(i);
    while (chq.size() < reps * expq.size() && n < 5000)
    begin
      @(negedge clk);
      n++;
    end
    for (int k = 0; k < reps * expq.size(); k++)
      chk("chan", chq.size() > k ? chq[k] : -1, expq[k % expq.size()]);
    chq.delete();
  endtask : check_seq
  task automatic run_once(input logic [3:0] l);
    lat = l;
    bus_wr(7'h4C, 16'h1000);
    wait_pin(1'h0);
    check_seq(1);
  endtask : run_once
  initial
  begin
    arst_n = 1'h0;
    reg_wr = 1'h0;
    rd = 1'h0;
    addr = 7'h00;
    wdata = 16'h0000;
    mask = 16'h8001;
    alarm = 1'h1;
    lat = 4'h3;
    sync_sel = 12'h000;
    exp_latch = '0;
    v = 16'($urandom(21));
    repeat (20) @(negedge clk);
    arst_n = 1'h1;
    @(negedge clk);
    chk("alarm_n", alarm_n, 1'h1);
    bus_rd(7'h4C, v);
    chk("word", v, 16'h2000);
    // reserved bits, reference, alarm enable; trigger 0 starts nothing
    bus_wr(7'h4C, 16'hC700);
    bus_rd(7'h4C, v);
    chk("word", v, 16'h0600);
    chk("ref_en", ref_en, 1'h1);
    chk("alarm_n", alarm_n, 1'h0);
    alarm = 1'h0;
    repeat (2) @(negedge clk);
    chk("alarm_n", alarm_n, 1'h1);
    repeat (20) @(negedge clk);
    chk("starts", chq.size(), 0);
    // one-shot runs; flag cleared by data read, new start, write 0
    mask = 16'($urandom) | 16'h8001;
    run_once(4'($urandom_range(1, 6)));
    bus_rd(7'h4C, v);
    chk("word", v, 16'h0080);
    chk("ref_en", ref_en, 1'h0);
    bus_rd(7'h23, v);
    repeat (2) @(negedge clk);
    chk("pin_n", pin_n, 1'h1);
    bus_rd(7'h4C, v);
    chk("word", v, 16'h0000);
    run_once(4'h1);
    lat = 4'h6;
    bus_wr(7'h4C, 16'h1000);
    repeat (4) @(negedge clk);
    bus_rd(7'h4C, v);
    chk("word", v, 16'h0000);
    wait_pin(1'h0);
    check_seq(1);
    bus_wr(7'h4C, 16'h0000);
    bus_rd(7'h4C, v);
    chk("word", v, 16'h0000);
    // auto mode repeats until mode is written 0
    // a sequence shorter than the pulse would merge the pulses into one
    mask = 16'hFFFF;
    lat = 4'($urandom_range(13, 15));
    bus_wr(7'h4C, 16'h3000);
    check_seq(2);
    bus_rd(7'h4C, v);
    chk("word", v, 16'h2000);
    wait_pin(1'h0);
    wait_pin(1'h1);
    bus_wr(7'h4C, 16'h0000);
    repeat (300) @(negedge clk);
    chq.delete();
    repeat (50) @(negedge clk);
    chk("starts", chq.size(), 0);
    // output data: async channels follow, sync ones wait for load
    sync_sel = 12'($urandom);
    for (int i = 0; i < 12; i++)
    begin
      dval = 12'($urandom);
      bus_wr(7'h33 + 7'(i), {4'h0, dval});
      if (!sync_sel[i]) exp_latch[12*i +: 12] = dval;
      else v[11:0] = dval;
      if (sync_sel[i]) exp_latch[12*i +: 12] = exp_latch[12*i +: 12];
      latch_next(i, dval);
    end
    repeat (3) @(negedge clk);
    chk("latch", latch, exp_latch);
    bus_wr(7'h4C, 16'h0800);
    exp_latch = pend_latch;
    repeat (3) @(negedge clk);
    chk("latch", latch, exp_latch);
    bus_rd(7'h4C, v);
    chk("word", v, 16'h0000);
    summarize();
  end
  // what the latches hold after the next load
  task automatic latch_next(input int i, input logic [11:0] d);
    pend_latch[12*i +: 12] = d;
  endtask : latch_next
endmodule : tb_top
